/* hw/mpc_pkg.sv */
package mpc_pkg;
	// ----------------------------------------
	// Register selection on the config port
	// ----------------------------------------
	localparam logic [1:0] REG_GPI_CFG = 2'h0;
	localparam logic [1:0] REG_GPI_STS = 2'h1;
	localparam logic [1:0] REG_GPIO_CFG = 2'h2;
	localparam logic [1:0] REG_GPIO_STS = 2'h3;
	// ----------------------------------------
	// Field positions in the config words
	// ----------------------------------------
	localparam int DRV_HI = 14;
	localparam int DRV_LO = 13;
	localparam int GPO_BIT = 12;
	localparam int TYPE_HI = 11;
	localparam int TYPE_LO = 10;
	localparam int POL_BIT = 9;
	localparam int PU_BIT = 8;
	localparam int PD_BIT = 7;
	localparam int FUNC_HI = 6;
	localparam int FUNC_LO = 0;
	// ----------------------------------------
	// Reset values and writable masks
	// ----------------------------------------
	localparam logic [15:0] GPI_CFG_RST = 16'h007F;
	localparam logic [15:0] GPIO_CFG_RST = 16'h0490;
	localparam logic [15:0] GPI_WMASK = 16'h03FF;
	localparam logic [15:0] GPIO_WMASK = 16'h7FFF;
	// ----------------------------------------
	// Pin function codes
	// ----------------------------------------
	localparam logic [6:0] FN_OE0 = 7'h00;
	localparam logic [6:0] FN_LATCH0 = 7'h05;
	localparam logic [6:0] FN_GOE = 7'h06;
	localparam logic [6:0] FN_REF0 = 7'h07;
	localparam logic [6:0] FN_REF1 = 7'h08;
	localparam logic [6:0] FN_LATCH1 = 7'h09;
	localparam logic [6:0] FN_SER_IN = 7'h0E;
	localparam logic [6:0] FN_SYNC = 7'h0F;
	localparam logic [6:0] FN_GPI = 7'h10;
	localparam logic [6:0] FN_LCS = 7'h11;
	localparam logic [6:0] FN_INT = 7'h1C;
	localparam logic [6:0] FN_GPO = 7'h1D;
	localparam logic [6:0] FN_SER_OUT = 7'h1E;
	localparam logic [6:0] FN_LOS0 = 7'h20;
	localparam logic [6:0] FN_REFLOS = 7'h24;
	localparam logic [6:0] FN_ALOCK = 7'h25;
	localparam logic [6:0] FN_DLOCK = 7'h26;
	localparam logic [6:0] FN_EVT0 = 7'h28;
	localparam logic [6:0] FN_ALOL = 7'h2D;
	localparam logic [6:0] FN_DLOL = 7'h2E;
	localparam logic [6:0] FN_LMT0 = 7'h30;
	localparam logic [6:0] FN_ALMT = 7'h35;
	localparam logic [6:0] FN_DLMT = 7'h36;
	localparam logic [6:0] FN_CLKMODE = 7'h37;
	localparam logic [6:0] FN_READY = 7'h38;
	localparam logic [6:0] FN_FAN1_CHOICE = 7'h39;
	localparam logic [6:0] FN_REFCLK = 7'h7F;
	localparam int NUM_GROUPS = 5;
	// ----------------------------------------
	// Pin types, level codes, driver groups
	// ----------------------------------------
	localparam logic [1:0] TYPE_PP = 2'h0;
	localparam logic [1:0] TYPE_IN2 = 2'h1;
	localparam logic [1:0] TYPE_OD = 2'h2;
	localparam logic [1:0] TYPE_IN3 = 2'h3;
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h3;
	localparam logic [2:0] GRP_FREE = 3'h7;
endpackage

/* hw/mpc_sync2.sv */
`timescale 1ns/1ps
// Two-stage synchroniser; only the second stage leaves the module
module mpc_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	// Metastable stage feeds nothing but the second stage
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

/* hw/mpc_pin_config.sv */
`timescale 1ns/1ps
module mpc_pin_config import mpc_pkg::*; #(
	parameter int NUM_GPI = 4,
	parameter int NUM_GPIO = 5,
	parameter int NUM_OUT = 4
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic cfg_wr_i,
	input wire logic [1:0] cfg_reg_i,
	input wire logic [2:0] cfg_idx_i,
	input wire logic [15:0] cfg_wdata_i,
	output logic [15:0] cfg_rdata_o,
	input wire logic [NUM_GPI-1:0] gpi_pin_i,
	output logic [NUM_GPI-1:0] gpi_pu_o,
	output logic [NUM_GPI-1:0] gpi_pd_o,
	output logic [NUM_GPI-1:0] gpi_refclk_o,
	input wire logic [2*NUM_GPIO-1:0] gpio_lvl_i,
	output logic [NUM_GPIO-1:0] gpio_out_o,
	output logic [NUM_GPIO-1:0] gpio_oe_o,
	output logic [NUM_GPIO-1:0] gpio_pu_o,
	output logic [NUM_GPIO-1:0] gpio_pd_o,
	output logic [NUM_GPIO-1:0] gpio_tri_o,
	output logic [2*NUM_GPIO-1:0] gpio_drv_o,
	input wire logic [3:0] los_sts_i,
	input wire logic refin_los_i,
	input wire logic apll_lock_i,
	input wire logic dpll_lock_i,
	input wire logic [4:0] los_evt_i,
	input wire logic apll_lol_i,
	input wire logic dpll_lol_i,
	input wire logic [4:0] los_lmt_i,
	input wire logic apll_lol_lmt_i,
	input wire logic dpll_lol_lmt_i,
	input wire logic fanout_clkmode_i,
	input wire logic device_ready_i,
	input wire logic fanout1_clock_choice_i,
	input wire logic irq_i,
	input wire logic serial_data_out_i,
	input wire logic serial_dir_out_i,
	input wire logic spi_3wire_i,
	input wire logic fanout0_choice_i,
	input wire logic fanout1_choice_i,
	input wire logic pll_locked_i,
	input wire logic [3*NUM_OUT-1:0] out_grp_i,
	input wire logic [NUM_OUT-1:0] out_dis_i,
	output logic [NUM_GROUPS-1:0] oe_group_o,
	output logic global_oe_o,
	output logic fanout0_sel_o,
	output logic fanout1_sel_o,
	output logic [1:0] dpll_ref_sel_o,
	output logic serial_data_in_o,
	output logic converter_sync_in_o,
	output logic [5:0] live_config_select_o,
	output logic [NUM_OUT-1:0] out_drv_en_o
);
	localparam int NPIN = NUM_GPI + NUM_GPIO;

	if (NUM_GPI < 1 || NUM_GPI > 4 || NUM_GPIO < 3 || NUM_GPIO > 5 || NUM_OUT < 1) begin : g_chk
		$error("mpc_pin_config: pin counts outside the status layout");
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [NUM_GPI-1:0] gpi_s;
	logic [2*NUM_GPIO-1:0] gpio_s;

	// Pads are asynchronous to the system clock
	mpc_sync2 #(.WIDTH(NPIN + NUM_GPIO)) u_sync (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.async_i({gpio_lvl_i, gpi_pin_i}),
		.sync_o({gpio_s, gpi_s})
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Functions with active-low naming
	function automatic logic low_active(input logic [6:0] f);
		return (f == FN_LATCH0) || (f == FN_LATCH1);
	endfunction

	// Output-direction function codes
	function automatic logic is_out_fn(input logic [6:0] f);
		return (f >= FN_INT) && (f != FN_REFCLK);
	endfunction

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [15:0] cfg_q [NPIN];
	logic wr_gpi, wr_gpio;
	logic [3:0] wr_slot;

	assign wr_gpi = cfg_wr_i && (cfg_reg_i == REG_GPI_CFG) && (32'(cfg_idx_i) < NUM_GPI);
	assign wr_gpio = cfg_wr_i && (cfg_reg_i == REG_GPIO_CFG) && (32'(cfg_idx_i) < NUM_GPIO);
	assign wr_slot = wr_gpio ? 4'(32'(cfg_idx_i) + NUM_GPI) : 4'(cfg_idx_i);

	// Reserved bits never take a write; status writes are dropped
	always_ff @(posedge clk_sys_i) begin
		for (int p = 0; p < NPIN; p++) begin
			if (srst_i) begin
				cfg_q[p] <= (p < NUM_GPI) ? GPI_CFG_RST : GPIO_CFG_RST;
			end else if ((wr_gpi || wr_gpio) && 32'(wr_slot) == p) begin
				cfg_q[p] <= cfg_wdata_i & ((p < NUM_GPI) ? GPI_WMASK : GPIO_WMASK);
			end
		end
	end

	// ----------------------------------------
	// Per-pin decode
	// ----------------------------------------
	logic [6:0] fn [NPIN];
	logic [1:0] ptype [NPIN];
	logic [1:0] lvl [NPIN];
	logic [NPIN-1:0] refclk, pol_eff, act;

	// Uniform view of both pin kinds; input pins use type 0x1
	always_comb begin
		for (int p = 0; p < NPIN; p++) begin
			fn[p] = cfg_q[p][FUNC_HI:FUNC_LO];
			ptype[p] = (p < NUM_GPI) ? TYPE_IN2 : cfg_q[p][TYPE_HI:TYPE_LO];
			lvl[p] = (p < NUM_GPI) ? {2{gpi_s[p]}} : gpio_s[2*(p-NUM_GPI) +: 2];
			refclk[p] = (p < NUM_GPI) && (fn[p] == FN_REFCLK);
			pol_eff[p] = cfg_q[p][POL_BIT] && !refclk[p]
				&& !(fn[p] == FN_LCS && ptype[p] == TYPE_IN3)
				&& (fn[p] != FN_GPO);
			act[p] = lvl[p][1] ^ pol_eff[p] ^ low_active(fn[p]);
		end
	end

	// ----------------------------------------
	// Input functions
	// ----------------------------------------
	logic [NUM_GROUPS-1:0] grp_any, grp_act;
	logic goe_any, goe_act, l0_act, l1_act;
	logic [1:0] ref_sel;
	logic ser_in, sync_in;

	// Unassigned enables default on; several pins on one code OR
	always_comb begin
		grp_any = '0;
		grp_act = '0;
		goe_any = 1'b0;
		goe_act = 1'b0;
		l0_act = 1'b0;
		l1_act = 1'b0;
		ref_sel = 2'h0;
		ser_in = 1'b0;
		sync_in = 1'b0;
		for (int p = 0; p < NPIN; p++) begin
			for (int g = 0; g < NUM_GROUPS; g++) begin
				if (fn[p] == FN_OE0 + 7'(g)) begin
					grp_any[g] = 1'b1;
					grp_act[g] = grp_act[g] | act[p];
				end
			end
			if (fn[p] == FN_GOE) begin
				goe_any = 1'b1;
				goe_act = goe_act | act[p];
			end
			l0_act = l0_act | (fn[p] == FN_LATCH0 && act[p]);
			l1_act = l1_act | (fn[p] == FN_LATCH1 && act[p]);
			ref_sel[0] = ref_sel[0] | (fn[p] == FN_REF0 && act[p]);
			ref_sel[1] = ref_sel[1] | (fn[p] == FN_REF1 && act[p]);
			ser_in = ser_in | (fn[p] == FN_SER_IN && act[p]);
			sync_in = sync_in | (fn[p] == FN_SYNC && act[p]);
		end
	end

	logic [NUM_GROUPS-1:0] grp_en;
	logic goe_en;
	assign grp_en = ~grp_any | grp_act;
	assign goe_en = !goe_any || goe_act;

	// Live config select: raw code when tri-level, else two-level
	logic [5:0] lcs;
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			if (fn[NUM_GPI+k] != FN_LCS) begin
				lcs[2*k +: 2] = LVL_LOW;
			end else if (ptype[NUM_GPI+k] == TYPE_IN3) begin
				lcs[2*k +: 2] = lvl[NUM_GPI+k];
			end else begin
				lcs[2*k +: 2] = act[NUM_GPI+k] ? LVL_HIGH : LVL_LOW;
			end
		end
	end

	// Latch edge detect on the active level
	logic l0_prev_q, l1_prev_q;
	logic l0_rise, l1_rise;
	assign l0_rise = l0_act && !l0_prev_q;
	assign l1_rise = l1_act && !l1_prev_q;

	// ----------------------------------------
	// Output sources
	// ----------------------------------------
	logic [63:0] src;
	always_comb begin
		src = '0;
		src[FN_INT[5:0]] = irq_i;
		src[FN_SER_OUT[5:0]] = serial_data_out_i;
		src[FN_LOS0[5:0] +: 4] = los_sts_i;
		src[FN_REFLOS[5:0]] = refin_los_i;
		src[FN_ALOCK[5:0]] = apll_lock_i;
		src[FN_DLOCK[5:0]] = dpll_lock_i;
		src[FN_EVT0[5:0] +: 5] = los_evt_i;
		src[FN_ALOL[5:0]] = apll_lol_i;
		src[FN_DLOL[5:0]] = dpll_lol_i;
		src[FN_LMT0[5:0] +: 5] = los_lmt_i;
		src[FN_ALMT[5:0]] = apll_lol_lmt_i;
		src[FN_DLMT[5:0]] = dpll_lol_lmt_i;
		src[FN_CLKMODE[5:0]] = fanout_clkmode_i;
		src[FN_READY[5:0]] = device_ready_i;
		src[FN_FAN1_CHOICE[5:0]] = fanout1_clock_choice_i;
	end

	// Pad controls for the bidirectional pins
	logic [NUM_GPIO-1:0] o_val, o_en, o_pu, o_pd, o_tri;
	logic [2*NUM_GPIO-1:0] o_drv;
	always_comb begin
		for (int k = 0; k < NUM_GPIO; k++) begin
			logic [6:0] f;
			logic v, sdio;
			f = fn[NUM_GPI+k];
			sdio = (f == FN_SER_OUT) && spi_3wire_i;
			v = (f == FN_GPO) ? cfg_q[NUM_GPI+k][GPO_BIT]
				: (src[f[5:0]] ^ pol_eff[NUM_GPI+k]);
			o_en[k] = 1'b0;
			o_val[k] = 1'b0;
			if (is_out_fn(f) && ptype[NUM_GPI+k] == TYPE_PP) begin
				o_en[k] = sdio ? serial_dir_out_i : 1'b1;
				o_val[k] = v;
			end else if (is_out_fn(f) && ptype[NUM_GPI+k] == TYPE_OD) begin
				o_en[k] = !v;
			end
			o_pu[k] = cfg_q[NUM_GPI+k][PU_BIT];
			o_pd[k] = cfg_q[NUM_GPI+k][PD_BIT];
			// Reserved on pins 3 and 4, so never sense tri-level there
			o_tri[k] = (ptype[NUM_GPI+k] == TYPE_IN3) && (k < 3);
			o_drv[2*k +: 2] = (ptype[NUM_GPI+k] == TYPE_PP || ptype[NUM_GPI+k] == TYPE_OD)
				? cfg_q[NUM_GPI+k][DRV_HI:DRV_LO] : 2'h0;
		end
	end

	// ----------------------------------------
	// Output driver enables
	// ----------------------------------------
	logic [NUM_OUT-1:0] drv_en;
	always_comb begin
		for (int d = 0; d < NUM_OUT; d++) begin
			logic [2:0] g;
			g = out_grp_i[3*d +: 3];
			if (out_dis_i[d]) begin
				drv_en[d] = 1'b0;
			end else if (g == GRP_FREE) begin
				drv_en[d] = 1'b1;
			end else if (32'(g) < NUM_GROUPS) begin
				drv_en[d] = grp_en[g] && goe_en && pll_locked_i;
			end else begin
				drv_en[d] = goe_en && pll_locked_i;
			end
		end
	end

	// ----------------------------------------
	// Status and readback
	// ----------------------------------------
	logic [7:0] gpi_sts, gpio_sts;
	logic [15:0] rd_mux;
	logic [3:0] rd_slot;
	always_comb begin
		gpi_sts = '0;
		gpio_sts = '0;
		for (int p = 0; p < NUM_GPI; p++) begin
			gpi_sts[p] = gpi_s[p] && !refclk[p];
		end
		for (int k = 0; k < 3; k++) begin
			gpio_sts[2*k +: 2] = gpio_s[2*k +: 2];
		end
		for (int k = 3; k < NUM_GPIO; k++) begin
			gpio_sts[3+k] = gpio_s[2*k+1];
		end
	end
	assign rd_slot = (cfg_reg_i == REG_GPIO_CFG) ? 4'(32'(cfg_idx_i) + NUM_GPI) : 4'(cfg_idx_i);
	assign rd_mux = (cfg_reg_i == REG_GPI_STS) ? {8'h00, gpi_sts}
		: (cfg_reg_i == REG_GPIO_STS) ? {8'h00, gpio_sts}
		: (cfg_reg_i == REG_GPI_CFG && 32'(cfg_idx_i) < NUM_GPI) ? cfg_q[rd_slot]
		: (cfg_reg_i == REG_GPIO_CFG && 32'(cfg_idx_i) < NUM_GPIO) ? cfg_q[rd_slot]
		: 16'h0000;

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			l0_prev_q <= 1'b0;
			l1_prev_q <= 1'b0;
			fanout0_sel_o <= 1'b0;
			fanout1_sel_o <= 1'b0;
		end else begin
			l0_prev_q <= l0_act;
			l1_prev_q <= l1_act;
			if (l0_rise) fanout0_sel_o <= fanout0_choice_i;
			if (l1_rise) fanout1_sel_o <= fanout1_choice_i;
		end
	end

	// Pad and function outputs; pads stay inputs with pull-down in reset
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			gpi_pu_o <= '0;
			gpi_pd_o <= '1;
			gpi_refclk_o <= '1;
			gpio_out_o <= '0;
			gpio_oe_o <= '0;
			gpio_pu_o <= '0;
			gpio_pd_o <= '1;
			gpio_tri_o <= '0;
			gpio_drv_o <= '0;
			oe_group_o <= '0;
			global_oe_o <= 1'b0;
			dpll_ref_sel_o <= 2'h0;
			serial_data_in_o <= 1'b0;
			converter_sync_in_o <= 1'b0;
			live_config_select_o <= '0;
			out_drv_en_o <= '0;
			cfg_rdata_o <= '0;
		end else begin
			for (int p = 0; p < NUM_GPI; p++) begin
				gpi_pu_o[p] <= cfg_q[p][PU_BIT] && !refclk[p];
				gpi_pd_o[p] <= cfg_q[p][PD_BIT] || refclk[p];
			end
			gpi_refclk_o <= refclk[NUM_GPI-1:0];
			gpio_out_o <= o_val;
			gpio_oe_o <= o_en;
			gpio_pu_o <= o_pu;
			gpio_pd_o <= o_pd;
			gpio_tri_o <= o_tri;
			gpio_drv_o <= o_drv;
			oe_group_o <= grp_en;
			global_oe_o <= goe_en;
			dpll_ref_sel_o <= ref_sel;
			serial_data_in_o <= ser_in;
			converter_sync_in_o <= sync_in;
			live_config_select_o <= lcs;
			out_drv_en_o <= drv_en;
			cfg_rdata_o <= rd_mux;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	sequence s_latch_idle;
		!l0_act;
	endsequence
	sequence s_latch_edge;
		s_latch_idle ##1 l0_act;
	endsequence

	latch_edge_a: assert property (s_latch_edge |=> fanout0_sel_o == $past(fanout0_choice_i))
		else $error("fanout0 selection not latched on edge");
	latch_hold_a: assert property (!l0_rise |=> $stable(fanout0_sel_o))
		else $error("fanout0 selection moved without edge");
	refclk_pull_a: assert property (refclk[0] |=> gpi_pd_o[0] && !gpi_pu_o[0])
		else $error("refclk pin pulls wrong");
	refclk_sts_a: assert property (refclk[0] && cfg_reg_i == REG_GPI_STS |=> !cfg_rdata_o[0])
		else $error("refclk pin status not zero");
	gpo_value_a: assert property (fn[NUM_GPI] == FN_GPO && ptype[NUM_GPI] == TYPE_PP
		|=> gpio_oe_o[0] && gpio_out_o[0] == $past(cfg_q[NUM_GPI][GPO_BIT]))
		else $error("plain output value wrong");
	open_drain_a: assert property (ptype[NUM_GPI] == TYPE_OD |=> !gpio_out_o[0])
		else $error("open drain pin drove high");
	drive_gate_a: assert property (ptype[NUM_GPI] == TYPE_IN2 |=> gpio_drv_o[1:0] == 2'h0)
		else $error("drive strength on input pin");
	int_route_a: assert property (fn[NUM_GPI] == FN_INT && ptype[NUM_GPI] == TYPE_PP
		&& !cfg_q[NUM_GPI][POL_BIT] |=> gpio_out_o[0] == $past(irq_i))
		else $error("interrupt not routed");
	free_run_a: assert property (out_grp_i[2:0] == GRP_FREE && !out_dis_i[0] |=> out_drv_en_o[0])
		else $error("free driver not enabled");
	reset_pull_a: assert property ($past(srst_i) |-> gpio_pd_o == '1 && gpio_pu_o == '0)
		else $error("bidir pulls wrong after reset");
endmodule

/* bench/mpc_board_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Board pads around the pin block
// ----------------------------------------
// A floating pad flips every cycle, so logic that samples it never
// sees a steady value by luck.
module mpc_board_model (
	input wire logic clk_sys_i,
	input wire logic [3:0] gpi_ext_en_i,
	input wire logic [3:0] gpi_ext_i,
	input wire logic [3:0] gpi_pu_i,
	input wire logic [3:0] gpi_pd_i,
	output logic [3:0] gpi_pin_o,
	input wire logic [4:0] gpio_ext_en_i,
	input wire logic [9:0] gpio_ext_i,
	input wire logic [4:0] gpio_out_i,
	input wire logic [4:0] gpio_oe_i,
	input wire logic [4:0] gpio_pu_i,
	input wire logic [4:0] gpio_pd_i,
	output logic [9:0] gpio_lvl_o
);
	logic flip_q = 1'b0;

	// Wander pattern for pads nobody drives
	always @(posedge clk_sys_i) begin
		flip_q <= ~flip_q;
	end

	// Device driver wins, then the board, then the pulls
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			gpi_pin_o[k] = gpi_ext_en_i[k] ? gpi_ext_i[k] : gpi_pu_i[k] ? 1'b1 :
				gpi_pd_i[k] ? 1'b0 : flip_q;
		end
		for (int k = 0; k < 5; k++) begin
			gpio_lvl_o[2*k+:2] = gpio_oe_i[k] ? {2{gpio_out_i[k]}} : gpio_ext_en_i[k] ?
				gpio_ext_i[2*k+:2] : gpio_pu_i[k] ? 2'h3 : gpio_pd_i[k] ? 2'h0 : {2{flip_q}};
		end
	end
endmodule

/* bench/multifunction_pin_config_tb.sv */
`timescale 1ns/1ps
module multifunction_pin_config_tb import mpc_pkg::*;;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic cfg_wr_i = 1'b0;
	logic [1:0] cfg_reg_i = 2'h0;
	logic [2:0] cfg_idx_i = 3'h0;
	logic [15:0] cfg_wdata_i = 16'h0000;
	logic [31:0] st = 32'h00000000;
	logic [11:0] out_grp_i = 12'h000;
	logic [3:0] out_dis_i = 4'h0;
	logic [3:0] gx = 4'h0;
	logic [9:0] px = 10'h000;
	logic [15:0] cfg_rdata_o, rv;
	logic [3:0] gpi_pin_i, gpi_pu_o, gpi_pd_o, gpi_refclk_o, out_drv_en_o;
	logic [9:0] gpio_lvl_i, gpio_drv_o;
	logic [4:0] gpio_out_o, gpio_oe_o, gpio_pu_o, gpio_pd_o, gpio_tri_o, oe_group_o;
	logic global_oe_o, fanout0_sel_o, fanout1_sel_o, serial_data_in_o, converter_sync_in_o;
	logic [1:0] dpll_ref_sel_o;
	logic [5:0] live_config_select_o;
	int error_cnt = 0;
	int n_tests = 0;

	// Status sources all come from one vector so none is tied off
	mpc_pin_config dut (.clk_sys_i, .srst_i, .cfg_wr_i, .cfg_reg_i, .cfg_idx_i, .cfg_wdata_i,
		.cfg_rdata_o, .gpi_pin_i, .gpi_pu_o, .gpi_pd_o, .gpi_refclk_o, .gpio_lvl_i, .gpio_out_o,
		.gpio_oe_o, .gpio_pu_o, .gpio_pd_o, .gpio_tri_o, .gpio_drv_o, .los_sts_i(st[3:0]),
		.refin_los_i(st[4]), .apll_lock_i(st[5]), .dpll_lock_i(st[6]), .los_evt_i(st[11:7]),
		.apll_lol_i(st[12]), .dpll_lol_i(st[13]), .los_lmt_i(st[18:14]),
		.apll_lol_lmt_i(st[19]), .dpll_lol_lmt_i(st[20]), .fanout_clkmode_i(st[21]),
		.device_ready_i(st[22]), .fanout1_clock_choice_i(st[23]), .irq_i(st[24]),
		.serial_data_out_i(st[25]), .serial_dir_out_i(st[26]), .spi_3wire_i(st[27]),
		.fanout0_choice_i(st[28]), .fanout1_choice_i(st[29]), .pll_locked_i(st[30]),
		.out_grp_i, .out_dis_i, .oe_group_o, .global_oe_o, .fanout0_sel_o, .fanout1_sel_o,
		.dpll_ref_sel_o, .serial_data_in_o, .converter_sync_in_o, .live_config_select_o,
		.out_drv_en_o);

	mpc_board_model board (.clk_sys_i, .gpi_ext_en_i(4'hF), .gpi_ext_i(gx),
		.gpi_pu_i(gpi_pu_o), .gpi_pd_i(gpi_pd_o), .gpi_pin_o(gpi_pin_i),
		.gpio_ext_en_i(5'h1F), .gpio_ext_i(px), .gpio_out_i(gpio_out_o), .gpio_oe_i(gpio_oe_o),
		.gpio_pu_i(gpio_pu_o), .gpio_pd_i(gpio_pd_o), .gpio_lvl_o(gpio_lvl_i));

	// 10 MHz system clock
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// ----------------------------------------
	// Port tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// Leading wait keeps back-to-back strobes one edge apart
	task automatic wr(input logic [1:0] r, input logic [2:0] i, input logic [15:0] d);
		@(negedge clk_sys_i);
		cfg_reg_i = r;
		cfg_idx_i = i;
		cfg_wdata_i = d;
		cfg_wr_i = 1'b1;
		@(negedge clk_sys_i);
		cfg_wr_i = 1'b0;
	endtask

	task automatic rd(input logic [1:0] r, input logic [2:0] i);
		cfg_reg_i = r;
		cfg_idx_i = i;
		repeat (2) @(negedge clk_sys_i);
		rv = cfg_rdata_o;
	endtask

	// Longest path is the latch at three edges; six leaves margin
	task automatic settle();
		repeat (6) @(negedge clk_sys_i);
	endtask

	function automatic logic fsel(input logic [6:0] c);
		case (c)
			FN_GOE: return global_oe_o;
			FN_REF0: return dpll_ref_sel_o[0];
			FN_REF1: return dpll_ref_sel_o[1];
			FN_SER_IN: return serial_data_in_o;
			FN_SYNC: return converter_sync_in_o;
			default: return oe_group_o[c[2:0]];
		endcase
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(REG_GPI_CFG, 3'h3);
		chk("gpi cfg", 16'h007F, rv); // input cfg
		rd(REG_GPIO_CFG, 3'h4);
		chk("gpio cfg", 16'h0490, rv); // bidir cfg
		chk("gpio pulls", 16'h001F, {gpio_pu_o, gpio_pd_o}); // pulls
		chk("gpio oe", 16'h0000, gpio_oe_o); // inputs
		chk("gpi refclk", 16'h0FF0, {gpi_refclk_o, gpi_pd_o, gpi_pu_o}); // pulls
		rd(REG_GPI_CFG, 3'h5);
		chk("bad idx", 16'h0000, rv); // no such pin
	endtask

	task automatic t_gpi_status();
		gx = 4'hF;
		wr(REG_GPI_CFG, 3'h0, 16'h017F);
		wr(REG_GPI_CFG, 3'h1, 16'h0310);
		wr(REG_GPI_STS, 3'h1, 16'hFFFF);
		wr(REG_GPI_CFG, 3'h3, 16'hFFFF);
		settle();
		chk("gpi pulls", 16'h0009, {gpi_pu_o[1:0], gpi_pd_o[1:0]}); // forced down
		rd(REG_GPI_STS, 3'h0);
		chk("gpi sts hi", 16'h0002, rv); // raw level
		rd(REG_GPI_CFG, 3'h3);
		chk("gpi rsvd", 16'h03FF, rv); // read-only zeros
		gx = 4'h0;
		settle();
		rd(REG_GPI_STS, 3'h0);
		chk("gpi sts lo", 16'h0000, rv); // no inversion
		wr(REG_GPI_CFG, 3'h3, 16'h007F);
	endtask

	task automatic t_gpi_funcs();
		logic [6:0] codes [10] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h07, 7'h08,
			7'h0E, 7'h0F};
		foreach (codes[k]) begin
			wr(REG_GPI_CFG, 3'h2, {9'h000, codes[k]});
			gx[2] = 1'b1;
			settle();
			chk("fn on", 16'h0001, fsel(codes[k])); // routed
			gx[2] = 1'b0;
			settle();
			chk("fn off", 16'h0000, fsel(codes[k])); // routed
		end
		wr(REG_GPI_CFG, 3'h2, 16'h0200);
		settle();
		chk("fn inv", 16'h0001, oe_group_o[0]); // sense
		wr(REG_GPI_CFG, 3'h2, 16'h007F);
	endtask

	task automatic t_latch();
		gx[3] = 1'b1;
		st[28] = 1'b1;
		wr(REG_GPI_CFG, 3'h3, 16'h0005);
		settle();
		gx[3] = 1'b0;
		settle();
		chk("latch0 set", 16'h0001, fanout0_sel_o); // falling edge
		st[28] = 1'b0;
		st[29] = 1'b1;
		settle();
		chk("latch0 hold", 16'h0001, fanout0_sel_o); // edge only
		wr(REG_GPI_CFG, 3'h3, 16'h0209);
		settle();
		chk("latch1 wait", 16'h0000, fanout1_sel_o); // no edge yet
		gx[3] = 1'b1;
		settle();
		chk("latch1 set", 16'h0001, fanout1_sel_o); // rising edge
		wr(REG_GPI_CFG, 3'h3, 16'h007F);
	endtask

	task automatic t_gpo();
		wr(REG_GPIO_CFG, 3'h0, 16'h721D);
		settle();
		chk("gpo pp", 16'h000F, {gpio_oe_o[0], gpio_out_o[0], gpio_drv_o[1:0]});
		wr(REG_GPIO_CFG, 3'h0, 16'h681D);
		settle();
		chk("gpo od", 16'h000B, {gpio_oe_o[0], gpio_out_o[0], gpio_drv_o[1:0]});
		wr(REG_GPIO_CFG, 3'h0, 16'h651D);
		settle();
		chk("gpo in", 16'h0000, {gpio_oe_o[0], gpio_drv_o[1:0]}); // no drive
		chk("gpio pull en", 16'h0002, {gpio_pu_o[0], gpio_pd_o[0]}); // own enables
		wr(REG_GPIO_CFG, 3'h0, 16'h0490);
	endtask

	task automatic t_outfuncs();
		logic [6:0] c;
		for (int k = 0; k < 25; k++) begin
			c = (k == 24) ? 7'h1C : 7'(k + ((k < 7) ? 32 : (k < 14) ? 33 : 34));
			wr(REG_GPIO_CFG, 3'h0, {9'h000, c});
			st[24:0] = 25'h1 << k;
			settle();
			chk("ofn on", 16'h0003, {gpio_oe_o[0], gpio_out_o[0]});
			st[24:0] = 25'h0;
			settle();
			chk("ofn off", 16'h0002, {gpio_oe_o[0], gpio_out_o[0]});
		end
		wr(REG_GPIO_CFG, 3'h0, 16'h0490);
	endtask

	task automatic t_ser_out();
		st[25] = 1'b1;
		wr(REG_GPIO_CFG, 3'h4, 16'h001E);
		settle();
		chk("ser out 4w", 16'h0003, {gpio_oe_o[4], gpio_out_o[4]}); // serial out
		st[27:26] = 2'b10;
		settle();
		chk("sdio in", 16'h0000, gpio_oe_o[4]); // 3-wire turnaround
		st[26:25] = 2'b10;
		settle();
		chk("sdio out", 16'h0002, {gpio_oe_o[4], gpio_out_o[4]}); // 3-wire drive
		st[27:25] = 3'h0;
		wr(REG_GPIO_CFG, 3'h4, 16'h0490);
	endtask

	task automatic t_bidir_sts();
		px = 10'b00_11_00_11_01;
		// Tri-level type only on pins 0 and 1
		wr(REG_GPIO_CFG, 3'h0, 16'h0C11);
		wr(REG_GPIO_CFG, 3'h1, 16'h0E10);
		settle();
		rd(REG_GPIO_STS, 3'h0);
		chk("gpio sts", 16'h004D, rv); // level codes
		chk("live sel", 16'h0001, live_config_select_o); // mid level
		chk("tri sense", 16'h0003, gpio_tri_o[1:0]);
		px[1:0] = 2'h3;
		settle();
		chk("live hi", 16'h0003, live_config_select_o); // high level
		px = 10'h000;
		wr(REG_GPIO_CFG, 3'h0, 16'h0490);
		wr(REG_GPIO_CFG, 3'h1, 16'h0490);
	endtask

	task automatic t_drivers();
		out_grp_i = {3'h5, 3'h5, 3'h0, 3'h7};
		settle();
		chk("drv unlocked", 16'h0001, out_drv_en_o); // free run
		st[30] = 1'b1;
		out_dis_i = 4'h9;
		settle();
		chk("drv dis", 16'h0006, out_drv_en_o); // own disable
		out_dis_i = 4'h0;
		wr(REG_GPI_CFG, 3'h2, 16'h0006);
		settle();
		chk("drv goe", 16'h0001, out_drv_en_o); // global off
		wr(REG_GPI_CFG, 3'h2, 16'h007F);
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic stop_test();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(negedge clk_sys_i);
		srst_i = 1'b0;
		t_reset();
		t_gpi_status();
		t_gpi_funcs();
		t_latch();
		t_gpo();
		t_outfuncs();
		t_ser_out();
		t_bidir_sts();
		t_drivers();
		stop_test();
	end

	// Run needs about 700 cycles; 20000 means a hang
	initial begin
		#(20000 * 100);
		error_cnt++;
		stop_test();
	end
endmodule
